// file: hw/uisp_regs.vh
// register offsets, field positions and reset values of the status/phy block
`ifndef UISP_REGS_VH
`define UISP_REGS_VH
`define UISP_OFF_PID      8'h2C
`define UISP_OFF_EP       8'h30
`define UISP_OFF_MARK     8'h34
`define UISP_OFF_OTGMASK  8'h38
`define UISP_OFF_PWRSIG   8'h3C
`define UISP_OFF_PHYCTL   8'h40
`define UISP_EP_VALID_BIT 4
`define UISP_MARK_OR      5'h10
`define UISP_PWR_VALID    8
`define UISP_PHY_PD_DIS   18
`define UISP_PHY_WK_SE0   13
`define UISP_PHY_WK_K     12
`define UISP_PHY_FLT_HI   11
`define UISP_PHY_FLT_LO   8
`define UISP_PHY_RESUME   7
`define UISP_PHY_CONF_HI  6
`define UISP_PHY_CONF_LO  4
`define UISP_LS_SE0       2'h0
`define UISP_LS_K         2'h2
`define UISP_RST_WORD     32'h00000000
`endif

// file: hw/uisp_ls_filter.v
// linestate glitch filter: holds a change off for 2**n clocks
`timescale 1ns/1ps
module uisp_ls_filter #(
	parameter W = 2
) (
	// clock and reset
	input  wire         clk_sys,
	input  wire         arst_n,
	// control
	input  wire [3:0]   log2_len,
	// linestate
	input  wire [W-1:0] ls_raw,
	output reg  [W-1:0] ls_filt
);
	reg [W-1:0] cand_reg;
	reg [15:0]  cnt_reg;
	wire [16:0] limit = 17'h00001 << log2_len;

	// restart count on change, pass on when stable long enough
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cand_reg <= {W{1'b0}};
			cnt_reg  <= 16'h0000;
			ls_filt  <= {W{1'b0}};
		end else if (ls_raw != cand_reg) begin
			cand_reg <= ls_raw;
			cnt_reg  <= 16'h0001;
		end else if ({1'b0, cnt_reg} >= limit) begin
			ls_filt <= cand_reg;
		end else begin
			cnt_reg <= cnt_reg + 16'h0001;
		end
	end
endmodule

// file: hw/uisp_wake_flag.v
// sticky wake cause flag: hardware set beats software clear
`timescale 1ns/1ps
module uisp_wake_flag (
	// clock and reset
	input  wire clk_sys,
	input  wire arst_n,
	// events
	input  wire set_pulse,
	input  wire clr_pulse,
	output reg  flag
);
	// set wins over clear
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			flag <= 1'b0;
		else if (set_pulse)
			flag <= 1'b1;
		else if (clr_pulse)
			flag <= 1'b0;
	end
endmodule

// file: hw/uisp_top.v
// status capture, endpoint marking and transceiver control registers
// Functional notes
// - capture 4-bit PID of each received packet; read-only, resets to zero
// - keep read-only 4-bit endpoint number of last received token
// - endpoint valid indicator beside captured endpoint number
// - 16-bit writable marking mask, one bit per endpoint, resets zero
// - marked endpoint delivered on receive port ORed with 0x10
// - writing 1 to pulldown-disable switches off both port pulldowns
// - auto-resume caused by SE0 sets sticky cause bit; write 0 clears
// - auto-resume caused by K sets sticky cause bit; write 0 clears
// - linestate change propagates only after 2**N stable clocks
// - resume-handling bit lets suspend controller resume; else software polls
// - three transceiver config pins driven from 3-bit writable field
`timescale 1ns/1ps
`include "uisp_regs.vh"
module uisp_top (
	// clock and reset
	input  wire        clk_sys,
	input  wire        arst_n,
	// wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	// receive side from packet decoder
	input  wire        rx_pkt_stb,
	input  wire [3:0]  rx_pid,
	input  wire        rx_tok_stb,
	input  wire [3:0]  rx_ep,
	input  wire        rx_ep_ok,
	output reg  [4:0]  rx_port_ep,
	output reg         rx_port_stb,
	// transceiver and suspend
	input  wire [1:0]  utmi_linestate,
	input  wire        suspended,
	output reg  [1:0]  linestate_filt,
	output reg         resume_req,
	output reg  [2:0]  transceiver_config_pins,
	output reg         pulldown_off,
	output reg  [7:0]  power_signal_value,
	output reg         power_signal_valid,
	output reg  [31:0] otg_mask_field
);
	reg  [3:0]  last_pid_field_reg;
	reg  [3:0]  ep_num_reg;
	reg         ep_valid_reg;
	reg  [15:0] mark_mask_reg;
	reg  [3:0]  filt_len_reg;
	reg         resume_en_reg;
	reg  [1:0]  ls_prev_reg;
	wire [1:0]  ls_f;
	wire        flag_se0;
	wire        flag_k;
	wire        req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire        wr   = req & wb_we_i;
	wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
	                     {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire [31:0] wd   = wb_dat_i & wmask;

	// register address hits
	wire hit_pid  = (wb_adr_i == `UISP_OFF_PID);
	wire hit_ep   = (wb_adr_i == `UISP_OFF_EP);
	wire hit_mark = (wb_adr_i == `UISP_OFF_MARK);
	wire hit_otg  = (wb_adr_i == `UISP_OFF_OTGMASK);
	wire hit_pwr  = (wb_adr_i == `UISP_OFF_PWRSIG);
	wire hit_phy  = (wb_adr_i == `UISP_OFF_PHYCTL);
	wire hit_any  = hit_pid | hit_ep | hit_mark
	              | hit_otg | hit_pwr | hit_phy;

	// decoded write strobes; read-only and unmapped offsets take none
	wire wr_mark = wr & hit_mark;
	wire wr_otg  = wr & hit_otg;
	wire wr_pwr  = wr & hit_pwr;
	wire wr_phy  = wr & hit_phy;

	// byte-lane write enables of the split registers
	wire wr_pwr_b0 = wr_pwr & wb_sel_i[0];
	wire wr_pwr_b1 = wr_pwr & wb_sel_i[1];
	wire wr_phy_b0 = wr_phy & wb_sel_i[0];
	wire wr_phy_b1 = wr_phy & wb_sel_i[1];
	wire wr_phy_b2 = wr_phy & wb_sel_i[2];

	// read strobe: data only for a read request
	wire rd_req = req & ~wb_we_i;

	// auto-resume event: filtered linestate moves while suspended
	wire ls_chg  = (ls_f != ls_prev_reg);
	wire wake    = resume_en_reg & suspended & ls_chg;
	wire set_se0 = wake & (ls_f == `UISP_LS_SE0);
	wire set_k   = wake & (ls_f == `UISP_LS_K);

	// cause bits clear on a written zero, a written one is ignored
	wire clr_se0 = wr_phy_b1 & ~wb_dat_i[`UISP_PHY_WK_SE0];
	wire clr_k   = wr_phy_b1 & ~wb_dat_i[`UISP_PHY_WK_K];

	// marking lookup for the endpoint on the receive side
	wire        ep_marked = mark_mask_reg[rx_ep];
	wire [4:0]  ep_plain  = {1'b0, rx_ep};
	wire [4:0]  ep_tagged = ep_plain | `UISP_MARK_OR;

	// next values of the masked full-lane registers
	wire [15:0] mark_mask_next = (mark_mask_reg & ~wmask[15:0]) | wd[15:0];
	wire [31:0] otg_mask_next  = (otg_mask_field & ~wmask) | wd;

	// linestate glitch filter
	uisp_ls_filter #(
		.W (2)
	) u_filt (
		.clk_sys  (clk_sys),
		.arst_n   (arst_n),
		.log2_len (filt_len_reg),
		.ls_raw   (utmi_linestate),
		.ls_filt  (ls_f)
	);

	// sticky cause flag for bus reset wake
	uisp_wake_flag u_wk_se0 (
		.clk_sys   (clk_sys),
		.arst_n    (arst_n),
		.set_pulse (set_se0),
		.clr_pulse (clr_se0),
		.flag      (flag_se0)
	);

	// sticky cause flag for resume wake
	uisp_wake_flag u_wk_k (
		.clk_sys   (clk_sys),
		.arst_n    (arst_n),
		.set_pulse (set_k),
		.clr_pulse (clr_k),
		.flag      (flag_k)
	);

	// last packet identifier
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			last_pid_field_reg <= 4'h0;
		else if (rx_pkt_stb)
			last_pid_field_reg <= rx_pid;
	end

	// last endpoint and its valid indicator, plain number only
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ep_num_reg   <= 4'h0;
			ep_valid_reg <= 1'b0;
		end else if (rx_tok_stb) begin
			ep_num_reg   <= rx_ep;
			ep_valid_reg <= rx_ep_ok;
		end
	end

	// receive port: one-cycle strobe, marked endpoints carry bit 4
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rx_port_ep  <= 5'h00;
			rx_port_stb <= 1'b0;
		end else begin
			rx_port_stb <= rx_tok_stb;
			if (rx_tok_stb && ep_marked)
				rx_port_ep <= ep_tagged;
			else if (rx_tok_stb)
				rx_port_ep <= ep_plain;
		end
	end

	// endpoint marking mask, low two byte lanes only
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			mark_mask_reg <= 16'h0000;
		else if (wr_mark)
			mark_mask_reg <= mark_mask_next;
	end

	// otg flag mask, full word with byte lanes
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			otg_mask_field <= `UISP_RST_WORD;
		else if (wr_otg)
			otg_mask_field <= otg_mask_next;
	end

	// power signalling value and valid
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			power_signal_value <= 8'h00;
			power_signal_valid <= 1'b0;
		end else begin
			if (wr_pwr_b0)
				power_signal_value <= wb_dat_i[7:0];
			if (wr_pwr_b1)
				power_signal_valid <= wb_dat_i[`UISP_PWR_VALID];
		end
	end

	// transceiver control fields
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			resume_en_reg           <= 1'b0;
			transceiver_config_pins <= 3'h0;
			filt_len_reg            <= 4'h0;
			pulldown_off            <= 1'b0;
		end else begin
			if (wr_phy_b0) begin
				resume_en_reg <= wb_dat_i[`UISP_PHY_RESUME];
				transceiver_config_pins <=
				    wb_dat_i[`UISP_PHY_CONF_HI:`UISP_PHY_CONF_LO];
			end
			if (wr_phy_b1)
				filt_len_reg <= wb_dat_i[`UISP_PHY_FLT_HI:`UISP_PHY_FLT_LO];
			if (wr_phy_b2)
				pulldown_off <= wb_dat_i[`UISP_PHY_PD_DIS];
		end
	end

	// filtered linestate copy and resume request pulse
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ls_prev_reg    <= 2'h0;
			linestate_filt <= 2'h0;
			resume_req     <= 1'b0;
		end else begin
			ls_prev_reg    <= ls_f;
			linestate_filt <= ls_f;
			resume_req     <= set_se0 | set_k;
		end
	end

	// plain read-back words
	wire [31:0] rd_pid_word  = {28'h0000000, last_pid_field_reg};
	wire [31:0] rd_mark_word = {16'h0000, mark_mask_reg};
	wire [31:0] rd_otg_word  = otg_mask_field;

	// endpoint read word, reserved bits zero
	reg  [31:0] rd_ep_word;
	always @* begin
		rd_ep_word = `UISP_RST_WORD;
		rd_ep_word[3:0] = ep_num_reg;
		rd_ep_word[`UISP_EP_VALID_BIT] = ep_valid_reg;
	end

	// power signalling read word, reserved bits zero
	reg  [31:0] rd_pwr_word;
	always @* begin
		rd_pwr_word = `UISP_RST_WORD;
		rd_pwr_word[7:0] = power_signal_value;
		rd_pwr_word[`UISP_PWR_VALID] = power_signal_valid;
	end

	// transceiver control read word, field by field
	reg  [31:0] rd_phy_word;
	always @* begin
		rd_phy_word = `UISP_RST_WORD;
		rd_phy_word[`UISP_PHY_PD_DIS] = pulldown_off;
		rd_phy_word[`UISP_PHY_WK_SE0] = flag_se0;
		rd_phy_word[`UISP_PHY_WK_K]   = flag_k;
		rd_phy_word[`UISP_PHY_FLT_HI:`UISP_PHY_FLT_LO] = filt_len_reg;
		rd_phy_word[`UISP_PHY_RESUME] = resume_en_reg;
		rd_phy_word[`UISP_PHY_CONF_HI:`UISP_PHY_CONF_LO] =
		    transceiver_config_pins;
	end

	// read word selection by address
	reg  [31:0] rd_word;
	always @* begin
		rd_word = `UISP_RST_WORD;
		if (!hit_any)
			rd_word = `UISP_RST_WORD;
		else if (hit_pid)
			rd_word = rd_pid_word;
		else if (hit_ep)
			rd_word = rd_ep_word;
		else if (hit_mark)
			rd_word = rd_mark_word;
		else if (hit_otg)
			rd_word = rd_otg_word;
		else if (hit_pwr)
			rd_word = rd_pwr_word;
		else if (hit_phy)
			rd_word = rd_phy_word;
	end

	// single-cycle ack; data stands only while ack does
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= `UISP_RST_WORD;
		end else begin
			wb_ack_o <= req;
			if (rd_req)
				wb_dat_o <= rd_word;
			else
				wb_dat_o <= `UISP_RST_WORD;
		end
	end
endmodule

// file: bench/uisp_top_asserts.sv
// concurrent checks on the status and transceiver control block ports
`timescale 1ns/1ps
module uisp_chk (
	// clock and reset
	input wire        clk_sys,
	input wire        arst_n,
	// register bus
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_we_i,
	input wire [7:0]  wb_adr_i,
	input wire [31:0] wb_dat_o,
	input wire        wb_ack_o,
	// receive side and pins
	input wire        rx_tok_stb,
	input wire [3:0]  rx_ep,
	input wire [4:0]  rx_port_ep,
	input wire        rx_port_stb,
	input wire        pulldown_off,
	input wire [2:0]  transceiver_config_pins
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	a_pid_rsv: assert property (wb_ack_o && wb_adr_i == 8'h2C
		|-> wb_dat_o[31:4] == 28'h0) else $error("pid reserved bits set");
	a_ep_rsv: assert property (wb_ack_o && wb_adr_i == 8'h30
		|-> wb_dat_o[31:5] == 27'h0) else $error("endpoint reserved set");
	a_mask_rsv: assert property (wb_ack_o && wb_adr_i == 8'h34
		|-> wb_dat_o[31:16] == 16'h0) else $error("mask reserved set");
	a_ctl_rsv: assert property (wb_ack_o && wb_adr_i == 8'h40
		|-> {wb_dat_o[31:19], wb_dat_o[17:14], wb_dat_o[3:0]} == 21'h0)
		else $error("control reserved set");
	a_ctl_pins: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h40
		|-> wb_dat_o[18] == pulldown_off
		&& wb_dat_o[6:4] == transceiver_config_pins) else $error("pins differ");
	a_tok_port: assert property (rx_tok_stb |=> rx_port_stb
		&& rx_port_ep[3:0] == $past(rx_ep)) else $error("port endpoint wrong");
endmodule
bind uisp_top uisp_chk i_uisp_chk (.clk_sys(clk_sys), .arst_n(arst_n),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.rx_tok_stb(rx_tok_stb), .rx_ep(rx_ep), .rx_port_ep(rx_port_ep),
	.rx_port_stb(rx_port_stb), .pulldown_off(pulldown_off),
	.transceiver_config_pins(transceiver_config_pins));

// file: bench/uisp_phy_model.sv
// transceiver and packet decoder stand-in for the receive side
`timescale 1ns/1ps
module uisp_phy_model (
	input  wire       clk_sys,
	output reg        rx_pkt_stb = 0,
	output reg  [3:0] rx_pid = 4'h0,
	output reg        rx_tok_stb = 0,
	output reg  [3:0] rx_ep = 4'h0,
	output reg        rx_ep_ok = 0,
	output reg  [1:0] ls = 2'h1
);
	// one-cycle strobes; fields scrambled once no longer valid
	task pkt(input [3:0] p);
		begin
			@(posedge clk_sys);
			rx_pkt_stb <= 1'b1;
			rx_pid <= p;
			@(posedge clk_sys);
			rx_pkt_stb <= 1'b0;
			rx_pid <= ~p;
		end
	endtask
	task tok(input [3:0] e, input o);
		begin
			@(posedge clk_sys);
			rx_tok_stb <= 1'b1;
			rx_ep <= e;
			rx_ep_ok <= o;
			@(posedge clk_sys);
			rx_tok_stb <= 1'b0;
			rx_ep <= ~e;
			rx_ep_ok <= ~o;
		end
	endtask
	// line state change at a clock edge
	task lset(input [1:0] v);
		begin
			@(posedge clk_sys);
			ls <= v;
		end
	endtask
endmodule

// file: bench/test_uisp_top.sv
// self-checking bench for the status and transceiver control block
`timescale 1ns/1ps
module test_uisp_top;
	// bus side, pins and bookkeeping
	reg         clk_sys = 0, arst_n = 0, suspended = 0;
	reg         wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	reg  [7:0]  wb_adr_i = 8'h00;
	reg  [3:0]  wb_sel_i = 4'hF, lanes = 4'hF;
	integer     n_resume = 0;
	reg  [31:0] wb_dat_i = 32'h0, q;
	wire [31:0] wb_dat_o, otg_mask_field;
	wire        wb_ack_o, rx_pkt_stb, rx_tok_stb, rx_ep_ok, rx_port_stb;
	wire        resume_req, pulldown_off, power_signal_valid;
	wire [3:0]  rx_pid, rx_ep;
	wire [4:0]  rx_port_ep;
	wire [1:0]  ls, linestate_filt;
	wire [2:0]  transceiver_config_pins;
	wire [7:0]  power_signal_value;
	integer     n_errors = 0, n_compared = 0, i;
	// 250 MHz clock
	always #2 clk_sys = ~clk_sys;
	uisp_top i_uisp_top (.clk_sys(clk_sys), .arst_n(arst_n),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_pkt_stb(rx_pkt_stb),
		.rx_pid(rx_pid), .rx_tok_stb(rx_tok_stb), .rx_ep(rx_ep),
		.rx_ep_ok(rx_ep_ok), .rx_port_ep(rx_port_ep),
		.rx_port_stb(rx_port_stb), .utmi_linestate(ls),
		.suspended(suspended), .linestate_filt(linestate_filt),
		.resume_req(resume_req), .pulldown_off(pulldown_off),
		.transceiver_config_pins(transceiver_config_pins),
		.power_signal_value(power_signal_value),
		.power_signal_valid(power_signal_valid),
		.otg_mask_field(otg_mask_field));
	uisp_phy_model i_uisp_phy_model (.clk_sys(clk_sys), .rx_pkt_stb(rx_pkt_stb),
		.rx_pid(rx_pid), .rx_tok_stb(rx_tok_stb), .rx_ep(rx_ep),
		.rx_ep_ok(rx_ep_ok), .ls(ls));
	// count resume request pulses
	always @(posedge clk_sys)
		if (resume_req === 1'b1)
			n_resume <= n_resume + 1;
	// compare and count
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("[FAIL] %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	// one classic bus cycle, held until ack is sampled
	task acc(input [7:0] a, input w, input [31:0] d);
		begin
			@(posedge clk_sys);
			wb_cyc_i <= 1'b1;
			wb_stb_i <= 1'b1;
			wb_we_i <= w;
			wb_sel_i <= lanes;
			wb_adr_i <= a;
			wb_dat_i <= d;
			@(posedge clk_sys);
			while (wb_ack_o !== 1'b1) @(posedge clk_sys);
			q = wb_dat_o;
			wb_cyc_i <= 1'b0;
			wb_stb_i <= 1'b0;
		end
	endtask
	task rd(input [7:0] a, input [31:0] e);
		begin
			acc(a, 1'b0, 32'h0);
			chk(q, e);
		end
	endtask
	// bounded wait for the filtered line state
	task wfilt(input [1:0] v);
		begin
			for (i = 0; i < 40 && linestate_filt !== v; i = i + 1)
				@(posedge clk_sys);
			chk({30'h0, linestate_filt}, {30'h0, v});
		end
	endtask
	task tokchk(input [3:0] e, input o, input [31:0] x);
		begin
			i_uisp_phy_model.tok(e, o);
			@(negedge clk_sys);
			chk({26'h0, rx_port_stb, rx_port_ep}, x);
		end
	endtask
	task print_verdict;
		begin
			$display("compared %0d errors %0d", n_compared, n_errors);
			if (n_errors == 0 && n_compared > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	// watchdog
	initial begin
		#20000;
		n_errors = n_errors + 1;
		print_verdict;
	end
	// test sequence
	initial begin
		repeat (4) @(posedge clk_sys);
		arst_n <= 1'b1;
		rd(8'h2C, 32'h0);
		rd(8'h30, 32'h0);
		rd(8'h34, 32'h0);
		rd(8'h40, 32'h0);
		rd(8'h44, 32'h0);
		acc(8'h34, 1'b1, 32'hFFFFFFFF);
		rd(8'h34, 32'h0000FFFF);
		acc(8'h34, 1'b1, 32'h00008020);
		tokchk(4'h5, 1'b1, 32'h35);
		rd(8'h30, 32'h15);
		tokchk(4'hF, 1'b1, 32'h3F);
		tokchk(4'h3, 1'b0, 32'h23);
		rd(8'h30, 32'h03);
		i_uisp_phy_model.pkt(4'hA);
		rd(8'h2C, 32'hA);
		acc(8'h40, 1'b1, 32'hFFFFFFFF);
		rd(8'h40, 32'h00040FF0);
		chk({pulldown_off, transceiver_config_pins}, 32'hF);
		acc(8'h40, 1'b1, 32'h200);
		wfilt(2'h1);
		suspended <= 1'b1;
		i_uisp_phy_model.lset(2'h2);
		i_uisp_phy_model.lset(2'h1);
		repeat (8) @(posedge clk_sys);
		chk(linestate_filt, 32'h1);
		i_uisp_phy_model.lset(2'h2);
		repeat (3) @(posedge clk_sys);
		chk(linestate_filt, 32'h1);
		wfilt(2'h2);
		rd(8'h40, 32'h200);
		i_uisp_phy_model.lset(2'h1);
		wfilt(2'h1);
		acc(8'h40, 1'b1, 32'h280);
		i_uisp_phy_model.lset(2'h2);
		wfilt(2'h2);
		rd(8'h40, 32'h1280);
		acc(8'h40, 1'b1, 32'h280);
		rd(8'h40, 32'h280);
		i_uisp_phy_model.lset(2'h0);
		wfilt(2'h0);
		rd(8'h40, 32'h2280);
		acc(8'h40, 1'b1, 32'h1280);
		rd(8'h40, 32'h280);
		chk(n_resume, 32'h2);
		lanes = 4'h2;
		acc(8'h34, 1'b1, 32'h0);
		lanes = 4'h1;
		acc(8'h40, 1'b1, 32'hFFFFFFFF);
		lanes = 4'hF;
		rd(8'h34, 32'h0020);
		rd(8'h40, 32'h2F0);
		acc(8'h3C, 1'b1, 32'hFFFFFFFF);
		rd(8'h3C, 32'h1FF);
		chk({power_signal_valid, power_signal_value}, 32'h1FF);
		acc(8'h38, 1'b1, 32'hA5C30F96);
		rd(8'h38, 32'hA5C30F96);
		chk(otg_mask_field, 32'hA5C30F96);
		print_verdict;
	end
endmodule
